// ### hdl/remote_status_reporting.sv
`timescale 1ns/10ps
// What this block does
// RULE_01: Lockout command ignores all keys, local too
// RULE_02: Only go-to-local command leaves remote mode
// RULE_03: Version query answers fixed 1999.0
// RULE_04: Serial poll shows request flag, bit 6
// RULE_05: Status query shows summary in bit 6
// RULE_06: Status byte bits 0, 1 read zero
// RULE_07: Bit 2 set while queue non-empty
// RULE_08: Bit 3 from enabled questionable events
// RULE_09: Bit 4 when response bytes ready
// RULE_10: Bit 5 when any enabled event bit set
// RULE_11: Master summary from enabled status bits
// RULE_12: New request sets flag, drives request line
// RULE_13: Bit 7 from enabled operation events
// RULE_14: Event bits set from queued error codes
// RULE_15: Bit 0 on complete, codes -800..-899
// RULE_16: Bit 2 query error, codes -400..-499
// RULE_17: Bit 3 device error, -300..-399, 100..999
// RULE_18: Bit 4 execution error, codes -200..-299
// RULE_19: Bit 5 command error, codes -100..-199
// RULE_20: Bit 7 at power-on; others read zero
// RULE_21: Queue holds 255, oldest first, clearable
// RULE_22: Event register read returns, then clears
// RULE_23: Host-writable request and event enable masks
module remote_status_reporting
   import status_pkg::*;
#(
   parameter int QDEPTH = QUEUE_DEPTH
) (
   input  wire logic              mclk,
   input  wire logic              reset_n,
   // Decoded host commands, one-cycle pulses
   input  wire logic              remote_cmd,
   input  wire logic              remote_with_lockout_cmd,
   input  wire logic              go_to_local_cmd,
   input  wire logic              language_version_query,
   input  wire logic              status_byte_query,
   input  wire logic              serial_poll,
   input  wire logic              event_register_query,
   input  wire logic              clear_status_cmd,
   input  wire logic              error_next_query,
   input  wire logic              request_enable_write,
   input  wire logic              event_enable_write,
   input  wire logic [7:0]        write_data,
   // Error sources
   input  wire logic              error_push,
   input  wire logic signed [15:0] error_code,
   input  wire logic              operation_complete,
   // Summary inputs from neighbouring registers
   input  wire logic [15:0]       questionable_summary,
   input  wire logic [15:0]       questionable_enable,
   input  wire logic [15:0]       operation_summary,
   input  wire logic [15:0]       operation_enable,
   input  wire logic              message_ready,
   // Front panel
   input  wire logic              panel_key,
   input  wire logic              panel_local_key,
   // Results
   output logic                   panel_key_accept,
   output logic                   remote_active,
   output logic                   lockout_active,
   output logic [15:0]            reply_data,
   output logic                   reply_valid,
   output logic [15:0]            status_summary_byte,
   output logic [15:0]            standard_event_flags,
   output logic                   service_request
);
   error_queue_if     eq ();                 // Queue port bundle
   remote_mode_e      mode_r;                // Local / remote / lockout
   logic [7:0]        request_enable_r;      // Service request enable mask
   logic [7:0]        event_enable_r;        // Standard event enable mask
   logic [15:0]       event_r;               // Standard event register
   logic [15:0]       event_set;             // Bits to set this cycle
   logic [7:0]        stb;                   // Live status byte, bit 6 clear
   logic              master_summary;        // Enabled summary of stb
   logic              rqs_r;                 // Request flag
   logic              master_summary_q_r;    // Previous master summary
   logic              pon_pending_r;         // Power-on flag waiting to post

   // Queue instance
   error_queue #(
      .DEPTH (QDEPTH)
   ) u_queue (
      .mclk    (mclk),
      .reset_n (reset_n),
      .q       (eq)
   );

   // Queue control: push codes, pop on error read, clear on clear-status
   assign eq.push      = error_push;                                  // RULE_21
   assign eq.push_code = error_code;
   assign eq.pop       = error_next_query;                            // RULE_21
   assign eq.clear     = clear_status_cmd;                            // RULE_21

   // Remote mode; only the local command leaves remote, panel has no say
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         mode_r <= MODE_LOCAL;
      end else if (go_to_local_cmd) begin
         mode_r <= MODE_LOCAL;                                        // RULE_02
      end else if (remote_with_lockout_cmd) begin
         mode_r <= MODE_LOCKOUT;                                      // RULE_01
      end else if (remote_cmd && mode_r != MODE_LOCKOUT) begin
         mode_r <= MODE_REMOTE;
      end
   end

   // Panel key gating: remote and lockout both block every key, the local key included
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         panel_key_accept <= 1'b0;
      end else begin
         case (mode_r)
            MODE_LOCAL:   panel_key_accept <= panel_key || panel_local_key;
            MODE_REMOTE:  panel_key_accept <= 1'b0;
            MODE_LOCKOUT: panel_key_accept <= 1'b0;                   // RULE_01
            default:      panel_key_accept <= 1'b0;
         endcase
      end
   end

   // Mode flags seen outside
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         remote_active  <= 1'b0;
         lockout_active <= 1'b0;
      end else begin
         remote_active  <= (mode_r != MODE_LOCAL);
         lockout_active <= (mode_r == MODE_LOCKOUT);
      end
   end

   // Enable masks written by the host
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         request_enable_r <= 8'h00;
         event_enable_r   <= 8'h00;
      end else begin
         if (request_enable_write) begin
            request_enable_r <= write_data;                           // RULE_23
         end
         if (event_enable_write) begin
            event_enable_r <= write_data;                             // RULE_23
         end
      end
   end

   // Map an incoming code to its event bit by range
   always_comb begin
      int c;
      c = int'(error_code);
      event_set = 16'h0000;
      if (error_push) begin                                           // RULE_14
         if (c >= CODE_OPC_LO && c <= CODE_OPC_HI) begin
            event_set[EV_OPC_BIT] = 1'b1;                             // RULE_15
         end
         if (c >= CODE_QYE_LO && c <= CODE_QYE_HI) begin
            event_set[EV_QYE_BIT] = 1'b1;                             // RULE_16
         end
         if ((c >= CODE_DDE_LO && c <= CODE_DDE_HI) || (c >= CODE_DEV_LO && c <= CODE_DEV_HI)) begin
            event_set[EV_DDE_BIT] = 1'b1;                             // RULE_17
         end
         if (c >= CODE_EXE_LO && c <= CODE_EXE_HI) begin
            event_set[EV_EXE_BIT] = 1'b1;                             // RULE_18
         end
         if (c >= CODE_CME_LO && c <= CODE_CME_HI) begin
            event_set[EV_CME_BIT] = 1'b1;                             // RULE_19
         end
      end
      if (operation_complete) begin
         event_set[EV_OPC_BIT] = 1'b1;                                // RULE_15
      end
      // Query error is posted only through its queued code range
      if (pon_pending_r) begin
         event_set[EV_PON_BIT] = 1'b1;                                // RULE_20
      end
   end

   // Power-on marker posts once, the first cycle after reset release
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pon_pending_r <= 1'b1;
      end else begin
         pon_pending_r <= 1'b0;                                       // RULE_20
      end
   end

   // Event register: read clears, but a set in the same cycle wins
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         event_r <= 16'h0000;
      end else if (event_register_query || clear_status_cmd) begin
         event_r <= event_set & EV_USED_MASK;                         // RULE_22
      end else begin
         event_r <= (event_r | event_set) & EV_USED_MASK;             // RULE_20
      end
   end

   // Live status byte from its sources; bit 6 is filled in per reader
   always_comb begin
      stb = 8'h00;                                                    // RULE_06
      stb[SB_QUEUE_BIT] = eq.not_empty;                               // RULE_07
      stb[SB_QUESTIONABLE_SUMMARY_BIT]  = |(questionable_summary & questionable_enable); // RULE_08
      stb[SB_MAV_BIT]   = message_ready;                              // RULE_09
      stb[SB_ESB_BIT]   = |(event_r & {8'h00, event_enable_r});       // RULE_10
      stb[SB_OPERATION_SUMMARY_BIT]  = |(operation_summary & operation_enable);    // RULE_13
   end

   // Bit 6 of the enable mask is ignored, as the summary cannot feed itself
   assign master_summary = |(stb & request_enable_r & ~(8'h01 << SB_RQS_BIT)); // RULE_11

   // Request flag: set on a rising summary, cleared by poll or when summary drops
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rqs_r              <= 1'b0;
         master_summary_q_r <= 1'b0;
      end else begin
         master_summary_q_r <= master_summary;
         if (master_summary && !master_summary_q_r) begin
            rqs_r <= 1'b1;                                            // RULE_12
         end else if (serial_poll || !master_summary) begin
            rqs_r <= 1'b0;
         end
      end
   end

   // Request line toward the controller follows the flag
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         service_request <= 1'b0;
      end else begin
         service_request <= rqs_r || (master_summary && !master_summary_q_r); // RULE_12
      end
   end

   // Mirrors of the two registers for direct observation
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         status_summary_byte  <= 16'h0000;
         standard_event_flags <= 16'h0000;
      end else begin
         status_summary_byte  <= {8'h00, stb[7:7], master_summary, stb[5:0]}; // RULE_05
         standard_event_flags <= event_r;
      end
   end

   // Reply path: one answer word per query; poll, event read and error read also clear or pop status state
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         reply_data  <= 16'h0000;
         reply_valid <= 1'b0;
      end else begin
         reply_valid <= 1'b0;
         if (serial_poll) begin
            reply_data  <= {8'h00, stb[7:7], rqs_r, stb[5:0]};        // RULE_04
            reply_valid <= 1'b1;
         end else if (status_byte_query) begin
            reply_data  <= {8'h00, stb[7:7], master_summary, stb[5:0]}; // RULE_05
            reply_valid <= 1'b1;
         end else if (event_register_query) begin
            reply_data  <= event_r;                                   // RULE_22
            reply_valid <= 1'b1;
         end else if (language_version_query) begin
            reply_data  <= LANG_VERSION_YEAR;                         // RULE_03
            reply_valid <= 1'b1;
         end else if (error_next_query) begin
            reply_data  <= eq.head_code;                              // RULE_21
            reply_valid <= 1'b1;
         end
      end
   end
endmodule

// ### hdl/status_pkg.sv
package status_pkg;
   // Status byte bit positions
   localparam int SB_QUEUE_BIT = 2;
   localparam int SB_QUESTIONABLE_SUMMARY_BIT  = 3;
   localparam int SB_MAV_BIT   = 4;
   localparam int SB_ESB_BIT   = 5;
   localparam int SB_RQS_BIT   = 6;
   localparam int SB_OPERATION_SUMMARY_BIT  = 7;
   // Standard event bit positions
   localparam int EV_OPC_BIT   = 0;
   localparam int EV_QYE_BIT   = 2;
   localparam int EV_DDE_BIT   = 3;
   localparam int EV_EXE_BIT   = 4;
   localparam int EV_CME_BIT   = 5;
   localparam int EV_PON_BIT   = 7;
   // Bits that exist in the event register; the rest read zero
   localparam logic [15:0] EV_USED_MASK = 16'h00BD;
   // Error code range limits
   localparam int CODE_OPC_LO  = -899;
   localparam int CODE_OPC_HI  = -800;
   localparam int CODE_QYE_LO  = -499;
   localparam int CODE_QYE_HI  = -400;
   localparam int CODE_DDE_LO  = -399;
   localparam int CODE_DDE_HI  = -300;
   localparam int CODE_EXE_LO  = -299;
   localparam int CODE_EXE_HI  = -200;
   localparam int CODE_CME_LO  = -199;
   localparam int CODE_CME_HI  = -100;
   localparam int CODE_DEV_LO  = 100;
   localparam int CODE_DEV_HI  = 999;
   // Language version answer 1999.0, as year and fraction
   localparam logic [15:0] LANG_VERSION_YEAR = 16'h07CF;
   localparam logic [3:0]  LANG_VERSION_FRAC = 4'h0;
   // Queue depth
   localparam int QUEUE_DEPTH  = 255;
   // Remote mode states
   typedef enum logic [2:0] {
      MODE_LOCAL   = 3'b001,
      MODE_REMOTE  = 3'b010,
      MODE_LOCKOUT = 3'b100
   } remote_mode_e;
endpackage

// ### hdl/error_queue_if.sv
`timescale 1ns/10ps
// Push/pop/clear path between the status core and the error queue
interface error_queue_if;
   logic              push;      // Add one code
   logic signed [15:0] push_code; // Code being added
   logic              pop;       // Remove the oldest code
   logic              clear;     // Empty the queue
   logic signed [15:0] head_code; // Oldest code, zero when empty
   logic              not_empty; // At least one entry held
   logic              full;      // No room left
   modport owner (output push, push_code, pop, clear, input head_code, not_empty, full);
   modport store (input push, push_code, pop, clear, output head_code, not_empty, full);
endinterface

// ### hdl/error_queue.sv
`timescale 1ns/10ps
// Oldest-first store of error and event codes
module error_queue
   import status_pkg::*;
#(
   parameter int DEPTH = QUEUE_DEPTH
) (
   input  wire logic    mclk,
   input  wire logic    reset_n,
   error_queue_if.store q
);
   localparam int AW = $clog2(DEPTH);
   logic signed [15:0] mem_r [DEPTH];  // Entry storage
   logic [AW-1:0]      wr_ptr_r;      // Next free slot
   logic [AW-1:0]      rd_ptr_r;      // Oldest entry
   logic [AW:0]        count_r;       // Entries held
   logic               do_push;
   logic               do_pop;

   // A push into a full queue is dropped; newest entries are lost first
   assign do_push = q.push && !q.full && !q.clear;
   assign do_pop  = q.pop && (count_r != '0) && !q.clear;
   assign q.full      = (count_r == (AW+1)'(DEPTH));
   assign q.not_empty = (count_r != '0);
   assign q.head_code = q.not_empty ? mem_r[rd_ptr_r] : 16'sh0000;

   // Storage write, no reset needed for data
   always_ff @(posedge mclk) begin
      if (do_push) begin
         mem_r[wr_ptr_r] <= q.push_code;
      end
   end

   // Pointers and count; clear empties everything
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else if (q.clear) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         if (do_push) begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (do_pop) begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
         end
         if (do_push && !do_pop) begin
            count_r <= count_r + 1'b1;
         end else if (do_pop && !do_push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule

// ### tb/status_assertions.sv
`timescale 1ns/10ps
// Port-level checks on the status and remote-lock block
module status_assertions
   import status_pkg::*;
#(
   parameter int QDEPTH = QUEUE_DEPTH
) (
   input logic        mclk,
   input logic        reset_n,
   input logic        serial_poll,
   input logic        status_byte_query,
   input logic        event_register_query,
   input logic        language_version_query,
   input logic        go_to_local_cmd,
   input logic [15:0] questionable_summary,
   input logic [15:0] questionable_enable,
   input logic [15:0] operation_summary,
   input logic [15:0] operation_enable,
   input logic        message_ready,
   input logic        panel_key_accept,
   input logic        lockout_active,
   input logic [15:0] reply_data,
   input logic        reply_valid,
   input logic [15:0] status_summary_byte,
   input logic [15:0] standard_event_flags
);
   // One clock domain, so one default clocking and reset
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   // Level inputs get three edges to settle before bits are judged
   sb_reserved_zero_a: assert property (
      status_summary_byte[1:0] == 2'h0 && status_summary_byte[15:8] == 8'h00)
      else $error("status byte reserved bits set");
   ev_unused_zero_a: assert property (
      (standard_event_flags & ~EV_USED_MASK) == 16'h0000)
      else $error("unused event bits set");
   questionable_summary_summary_a: assert property (
      $stable(questionable_summary & questionable_enable)[*3]
      |-> status_summary_byte[SB_QUESTIONABLE_SUMMARY_BIT] == |(questionable_summary & questionable_enable))
      else $error("questionable summary bit wrong");
   operation_summary_summary_a: assert property (
      $stable(operation_summary & operation_enable)[*3]
      |-> status_summary_byte[SB_OPERATION_SUMMARY_BIT] == |(operation_summary & operation_enable))
      else $error("operation summary bit wrong");
   msg_ready_a: assert property (
      $stable(message_ready)[*3] |-> status_summary_byte[SB_MAV_BIT] == message_ready)
      else $error("message available bit wrong");
   // Event flags may lag the core by an edge, so look one edge back
   event_summary_a: assert property (
      (standard_event_flags != 16'h0000)[*4] |-> $past(status_summary_byte[SB_ESB_BIT]))
      else $error("event summary bit missing");
   lockout_keys_a: assert property (
      lockout_active && $past(lockout_active) |-> !panel_key_accept)
      else $error("key accepted under lockout");
   lockout_exit_a: assert property (
      $fell(lockout_active) |-> $past(go_to_local_cmd) || $past(go_to_local_cmd, 2))
      else $error("lockout left without local command");
   version_reply_a: assert property (
      language_version_query && !serial_poll && !status_byte_query && !event_register_query
      |=> reply_valid && reply_data == 16'h07CF)
      else $error("version reply wrong");
   poll_reply_a: assert property (
      serial_poll |=> reply_valid)
      else $error("serial poll not answered");
   status_reply_a: assert property (
      status_byte_query && !serial_poll |=> reply_valid)
      else $error("status query not answered");
endmodule
bind remote_status_reporting status_assertions #(.QDEPTH(QDEPTH)) i_chk (.*);

// ### tb/host_model.sv
`timescale 1ns/10ps
// Host controller: issues one decoded command pulse at a time
module host_model (
   input  logic        mclk,
   output logic [10:0] cmd_pulse,
   output logic [7:0]  wdata
);
   // Idle at time zero so no command is seen before reset ends
   initial begin
      cmd_pulse = 11'h000;
      wdata = 8'h00;
   end
   // Pulse for one edge, then a spare edge so pulses never merge
   task automatic send(input int idx, input logic [7:0] d);
      @(posedge mclk);
      cmd_pulse[idx] <= 1'b1;
      wdata <= d;
      @(posedge mclk);
      cmd_pulse <= 11'h000;
   endtask
endmodule

// ### tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   import status_pkg::*;
   localparam int QD = 4; // Short queue keeps overflow cheap to reach
   localparam int C_REM = 0, C_LOCK = 1, C_LOCAL = 2, C_VER = 3, C_SBQ = 4, C_POLL = 5;
   localparam int C_EVQ = 6, C_CLR = 7, C_NEXT = 8, C_REQEN = 9, C_EVEN = 10;
   logic        mclk = 1'b0;
   logic        reset_n = 1'b0;
   logic [10:0] hc;
   logic [7:0]  wd;
   logic        epush = 1'b0, op_done = 1'b0, mrdy = 1'b0, pkey = 1'b0, plkey = 1'b0;
   logic [15:0] ecode = 16'h0000, qs = 16'h0000, qe = 16'h0000, os = 16'h0000, oe = 16'h0000;
   logic        accept, remote, lockout, rvalid, srq, q3, o7;
   logic [15:0] rdata, sbyte, evflags;
   logic [31:0] seed = 32'h0000000A, r, s;
   logic [15:0] exp_q[$]; // Expected replies, oldest first
   int          num_errors = 0;
   int          n_tests = 0;
   int          codes[12] = '{-800, -899, -400, -499, -300, -399, 100, 999, -200, -299, -100, -199};
   logic [15:0] bits[12] = '{16'h0001, 16'h0001, 16'h0004, 16'h0004, 16'h0008, 16'h0008,
                             16'h0008, 16'h0008, 16'h0010, 16'h0010, 16'h0020, 16'h0020};

   always #5 mclk = ~mclk;
   host_model i_host (.mclk(mclk), .cmd_pulse(hc), .wdata(wd));
   remote_status_reporting #(.QDEPTH(QD)) i_dut (
      .mclk(mclk), .reset_n(reset_n), .remote_cmd(hc[C_REM]), .remote_with_lockout_cmd(hc[C_LOCK]),
      .go_to_local_cmd(hc[C_LOCAL]), .language_version_query(hc[C_VER]), .status_byte_query(hc[C_SBQ]),
      .serial_poll(hc[C_POLL]), .event_register_query(hc[C_EVQ]), .clear_status_cmd(hc[C_CLR]),
      .error_next_query(hc[C_NEXT]), .request_enable_write(hc[C_REQEN]), .event_enable_write(hc[C_EVEN]),
      .write_data(wd), .error_push(epush), .error_code(ecode), .operation_complete(op_done),
      .questionable_summary(qs), .questionable_enable(qe), .operation_summary(os),
      .operation_enable(oe), .message_ready(mrdy), .panel_key(pkey), .panel_local_key(plkey),
      .panel_key_accept(accept), .remote_active(remote), .lockout_active(lockout),
      .reply_data(rdata), .reply_valid(rvalid), .status_summary_byte(sbyte),
      .standard_event_flags(evflags), .service_request(srq));

   function automatic logic [31:0] xorshift();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] want);
      n_tests++;
      if (got !== want) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, want);
      end
   endtask
   // Let n edges land, then sample at the falling edge
   task automatic settle(input int n);
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask
   // Note the expected reply, then let the host ask
   task automatic ask(input int idx, input logic [15:0] v);
      exp_q.push_back(v);
      i_host.send(idx, 8'h00);
   endtask
   task automatic push(input logic [15:0] c);
      @(posedge mclk);
      epush <= 1'b1;
      ecode <= c;
      @(posedge mclk);
      epush <= 1'b0;
   endtask
   task automatic results();
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Each reply pulse takes the oldest note; a reply with no note is an error
   always @(posedge mclk) begin
      if (rvalid === 1'b1 && exp_q.size() > 0)
         chk(rdata, exp_q.pop_front());
      else if (rvalid === 1'b1)
         chk(16'h0000, 16'h0001);
   end

   // A hang counts as a failure and still prints the verdict
   initial begin
      #100us;
      num_errors++;
      results();
   end

   initial begin
      repeat (8) @(posedge mclk);
      reset_n <= 1'b1;
      // Enable mask first, so the power-on bit already feeds the summary
      i_host.send(C_EVEN, 8'hFF);
      ask(C_EVQ, 16'h0080);
      settle(2);
      chk(evflags, 16'h0000);
      ask(C_VER, 16'h07CF);
      @(posedge mclk);
      op_done <= 1'b1;
      @(posedge mclk);
      op_done <= 1'b0;
      ask(C_EVQ, 16'h0001);
      // Every code range, both ends, each from a cleared register
      foreach (codes[i]) begin
         i_host.send(C_CLR, 8'h00);
         push(16'(codes[i]));
         ask(C_EVQ, bits[i]);
      end
      // Overfill the queue by one, then drain past empty
      i_host.send(C_CLR, 8'h00);
      for (int i = 1; i <= QD + 1; i++) push(16'(-100 - i));
      ask(C_SBQ, 16'h0024);
      for (int i = 1; i <= QD; i++) ask(C_NEXT, 16'(-100 - i));
      ask(C_NEXT, 16'h0000);
      ask(C_SBQ, 16'h0020);
      // Request raised by an enabled questionable bit, dropped by a poll
      i_host.send(C_CLR, 8'h00);
      i_host.send(C_REQEN, 8'h08);
      qs <= 16'h0100;
      qe <= 16'h0100;
      settle(3);
      chk({15'h0000, srq}, 16'h0001);
      ask(C_POLL, 16'h0048);
      ask(C_SBQ, 16'h0048);
      settle(1);
      chk({15'h0000, srq}, 16'h0000);
      // Random summary inputs against a two-bit request mask
      i_host.send(C_REQEN, 8'h88);
      repeat (6) begin
         r = xorshift();
         s = xorshift();
         @(posedge mclk);
         qs <= r[15:0];
         qe <= r[31:16];
         os <= s[15:0];
         oe <= s[31:16];
         mrdy <= s[7];
         q3 = |(r[15:0] & r[31:16]);
         o7 = |(s[15:0] & s[31:16]);
         settle(2);
         ask(C_SBQ, {8'h00, o7, q3 | o7, 1'b0, s[7], q3, 3'b000});
      end
      // Keys: accepted locally, refused in remote and in lockout
      @(posedge mclk);
      pkey <= 1'b1;
      settle(2);
      chk({13'h0000, remote, lockout, accept}, 16'h0001);
      i_host.send(C_REM, 8'h00);
      settle(3);
      chk({13'h0000, remote, lockout, accept}, 16'h0004);
      i_host.send(C_LOCK, 8'h00);
      @(posedge mclk);
      plkey <= 1'b1;
      settle(3);
      chk({13'h0000, remote, lockout, accept}, 16'h0006);
      i_host.send(C_LOCAL, 8'h00);
      settle(3);
      chk({13'h0000, remote, lockout, accept}, 16'h0001);
      settle(4);
      chk(16'(exp_q.size()), 16'h0000);
      results();
   end
endmodule
